// ==== rtl/ecc_pkg.sv ====
package ecc_pkg;
  // data path geometry
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int HAM_W = 6;
  localparam int CODE_W = 7;
  localparam int WORD_W = 39;
  localparam int CW_POS = 38;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int CNT_W = 16;
  // software register port
  localparam int REG_AW = 3;
  localparam int REG_DW = 32;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_MASK = 3'h2;
  localparam logic [2:0] REG_SBE_FLAG = 3'h3;
  localparam logic [2:0] REG_ERR_ADDR = 3'h4;
  localparam logic [2:0] REG_SBE_CNT = 3'h5;
  localparam logic [2:0] REG_DBE_CNT = 3'h6;
  localparam int ST_SBE_BIT = 0;
  localparam int ST_DBE_BIT = 1;
  localparam int ST_W = 2;
  localparam logic AUTO_RST = 1'h1;
  // control fields: auto correct, then two one-shot test flips
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_INJ_LO = 1;
  localparam int INJ_W = 2;
  // response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DERR = 2'h2;
  // clocking: bridge present or not, rate ratios
  localparam logic HALF_BRIDGE = 1'h0;
  localparam int HALF_DIV = 2;
  localparam int QUARTER_DIV = 4;
  localparam int DIV_W = 2;

  typedef enum logic [6:0] {
    DS_IDLE = 7'h01,
    DS_ENC = 7'h02,
    DS_RD = 7'h04,
    DS_CHK = 7'h08,
    DS_WR = 7'h10,
    DS_BRSP = 7'h20,
    DS_RRSP = 7'h40
  } ecc_dst_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_WREQ = 4'h2,
    HS_RREQ = 4'h4,
    HS_WAIT = 4'h8
  } ecc_hst_t;
endpackage

// ==== rtl/ecc_link_if.sv ====
`timescale 1ns/1ps
interface ecc_link_if;
  logic [ecc_pkg::ADDR_W-1:0] awaddr;
  logic awvalid;
  logic awready;
  logic [ecc_pkg::DATA_W-1:0] wdata;
  logic [ecc_pkg::BE_W-1:0] wstrb;
  logic wlast;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [ecc_pkg::ADDR_W-1:0] araddr;
  logic arvalid;
  logic arready;
  logic [ecc_pkg::DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rlast;
  logic rvalid;
  logic rready;
  logic hrate_en;
  logic qrate_en;

  modport dev (
    input awaddr, awvalid, wdata, wstrb, wlast, wvalid, bready,
    input araddr, arvalid, rready, hrate_en, qrate_en,
    output awready, wready, bresp, bvalid, arready,
    output rdata, rresp, rlast, rvalid
  );
  modport host (
    output awaddr, awvalid, wdata, wstrb, wlast, wvalid, bready,
    output araddr, arvalid, rready, hrate_en, qrate_en,
    input awready, wready, bresp, bvalid, arready,
    input rdata, rresp, rlast, rvalid
  );
endinterface

// ==== rtl/ecc_codec.sv ====
`timescale 1ns/1ps
module ecc_codec (
  input wire logic [ecc_pkg::DATA_W-1:0] i_enc_data,
  input wire logic [ecc_pkg::WORD_W-1:0] i_dec_word,
  output logic [ecc_pkg::CODE_W-1:0] o_code,
  output logic [ecc_pkg::DATA_W-1:0] o_data,
  output logic o_sbe,
  output logic o_dbe
);
  import ecc_pkg::*;

  // xor of the codeword positions of every set data bit
  function automatic logic [HAM_W-1:0] ham(input logic [DATA_W-1:0] d);
    logic [HAM_W-1:0] p;
    int idx;
    p = '0;
    idx = 0;
    for (int pos = 1; pos <= CW_POS; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        if (d[idx]) p = p ^ HAM_W'(pos);
        idx++;
      end
    end
    return p;
  endfunction

  logic [HAM_W-1:0] enc_p;
  logic [HAM_W-1:0] syn;
  logic [DATA_W-1:0] raw;

  // encoder: hamming bits plus overall parity over data and hamming bits
  always_comb begin
    enc_p = ham(i_enc_data);
    o_code = {^{i_enc_data, enc_p}, enc_p};
  end

  // decoder: odd overall parity means one flipped bit, even with a
  // nonzero syndrome means two; the data is never touched on two
  always_comb begin
    int idx;
    idx = 0;
    raw = i_dec_word[DATA_W-1:0];
    syn = ham(raw) ^ i_dec_word[DATA_W+HAM_W-1:DATA_W];
    o_sbe = ^i_dec_word;
    o_dbe = !o_sbe && (syn != '0);
    o_data = raw;
    for (int pos = 1; pos <= CW_POS; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        if (o_sbe && (HAM_W'(pos) == syn)) o_data[idx] = ~raw[idx];
        idx++;
      end
    end
  end
endmodule

// ==== rtl/ecc_dev_end.sv ====
`timescale 1ns/1ps
module ecc_dev_end (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  ecc_link_if.dev bus,
  input wire logic [ecc_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [ecc_pkg::REG_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [ecc_pkg::REG_DW-1:0] o_reg_rdata,
  output logic o_irq
);
  import ecc_pkg::*;

  ecc_dst_t st_reg;
  ecc_dst_t st_next;
  logic wr_rdy_reg;
  logic rd_rdy_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] wd_reg;
  logic [BE_W-1:0] be_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic op_rd_reg;
  logic [WORD_W-1:0] q_reg;
  logic [CODE_W-1:0] code_reg;
  logic [WORD_W-1:0] mem [DEPTH];
  logic auto_reg;
  logic [INJ_W-1:0] inj_reg;
  logic [ST_W-1:0] stat_reg;
  logic [ST_W-1:0] mask_reg;
  logic [ADDR_W-1:0] err_addr_reg;
  logic [CNT_W-1:0] sbe_cnt_reg;
  logic [CNT_W-1:0] dbe_cnt_reg;
  logic irq_reg;
  logic [REG_DW-1:0] reg_rdata_reg;
  logic [REG_DW-1:0] rd_mux;
  logic [CODE_W-1:0] enc_code;
  logic [DATA_W-1:0] dec_data;
  logic dec_sbe;
  logic dec_dbe;

  // one codec: encodes the staged word, checks the fetched one
  ecc_codec u_codec (
    .i_enc_data(wd_reg),
    .i_dec_word(q_reg),
    .o_code(enc_code),
    .o_data(dec_data),
    .o_sbe(dec_sbe),
    .o_dbe(dec_dbe)
  );

  // byte lane merge of new bytes over the checked word
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_d,
    input logic [DATA_W-1:0] new_d,
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] m;
    m = old_d;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) m[8*b +: 8] = new_d[8*b +: 8];
    end
    return m;
  endfunction

  // bridge side only moves on the slow synchronous enable
  wire bridge_en = HALF_BRIDGE ? bus.hrate_en : 1'h1;
  wire in_idle = (st_reg == DS_IDLE);
  // converter: address+data channels become one streaming command
  wire cmd_wr = in_idle && wr_rdy_reg && bus.awvalid && bus.wvalid;
  wire cmd_rd = in_idle && rd_rdy_reg && bus.arvalid;
  wire cmd_valid = cmd_wr || cmd_rd;
  wire [ADDR_W-1:0] cmd_addr = cmd_wr ? bus.awaddr : bus.araddr;
  // any low lane, all-low included, goes the read-modify-write way
  wire cmd_partial = !(&bus.wstrb);
  wire in_chk = (st_reg == DS_CHK);
  wire sbe_ev = in_chk && dec_sbe;
  wire dbe_ev = in_chk && dec_dbe;
  wire fix_rd = op_rd_reg && dec_sbe && auto_reg;
  wire [DATA_W-1:0] merged = merge(dec_data, wd_reg, be_reg);
  wire [ST_W-1:0] stat_set = {dbe_ev, sbe_ev};
  // armed flips hit data bits 0 and 1 of the next stored word only,
  // so the check path can be exercised without touching the array
  wire [WORD_W-1:0] inj_flip = WORD_W'(inj_reg);
  wire stat_wr = i_reg_wr && (i_reg_addr == REG_STAT);
  wire [ST_W-1:0] stat_clr = stat_wr ? i_reg_wdata[ST_W-1:0] : '0;
  // set wins over a clear landing in the same cycle
  wire [ST_W-1:0] stat_next = (stat_reg & ~stat_clr) | stat_set;

  assign bus.awready = wr_rdy_reg;
  assign bus.wready = wr_rdy_reg;
  assign bus.arready = rd_rdy_reg;
  assign bus.bvalid = bvalid_reg;
  assign bus.bresp = RESP_OKAY;
  assign bus.rvalid = rvalid_reg;
  assign bus.rdata = rdata_reg;
  assign bus.rresp = rresp_reg;
  assign bus.rlast = 1'h1;
  assign o_reg_rdata = reg_rdata_reg;
  assign o_irq = irq_reg;

  // command sequencer; nothing new is taken until back in idle
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      DS_IDLE: begin
        if (cmd_valid) begin
          if (cmd_wr && !cmd_partial) st_next = DS_ENC;
          else st_next = DS_RD;
        end
      end
      DS_ENC: st_next = DS_WR;
      DS_RD: st_next = DS_CHK;
      DS_CHK: begin
        // correction write-back runs before the read is answered
        if (!op_rd_reg || fix_rd) st_next = DS_ENC;
        else st_next = DS_RRSP;
      end
      DS_WR: st_next = op_rd_reg ? DS_RRSP : DS_BRSP;
      DS_BRSP: if (bus.bready) st_next = DS_IDLE;
      DS_RRSP: if (bus.rready) st_next = DS_IDLE;
      default: st_next = DS_IDLE;
    endcase
  end

  // state and handshake flops
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= DS_IDLE;
      wr_rdy_reg <= 1'h0;
      rd_rdy_reg <= 1'h0;
      bvalid_reg <= 1'h0;
      rvalid_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      wr_rdy_reg <= (st_next == DS_IDLE) && bridge_en && bus.awvalid &&
                    bus.wvalid;
      rd_rdy_reg <= (st_next == DS_IDLE) && bridge_en && bus.arvalid &&
                    !(bus.awvalid && bus.wvalid);
      bvalid_reg <= (st_next == DS_BRSP);
      rvalid_reg <= (st_next == DS_RRSP);
    end
  end

  // datapath staging
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wd_reg <= '0;
      be_reg <= '0;
      addr_reg <= '0;
      op_rd_reg <= 1'h0;
      q_reg <= '0;
      code_reg <= '0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      if (cmd_valid) begin
        addr_reg <= cmd_addr;
        op_rd_reg <= cmd_rd;
        wd_reg <= bus.wdata;
        be_reg <= bus.wstrb;
      end
      if (st_reg == DS_RD) q_reg <= mem[addr_reg];
      if (in_chk) begin
        // merge also runs on a double error: a fresh word goes back
        wd_reg <= op_rd_reg ? dec_data : merged;
        rdata_reg <= dec_data;
        rresp_reg <= dec_dbe ? RESP_DERR : RESP_OKAY;
      end
      if (st_reg == DS_ENC) code_reg <= enc_code;
    end
  end

  // memory array holds no reset; software initialises it first
  always_ff @(posedge i_clk) begin
    if (st_reg == DS_WR) mem[addr_reg] <= {code_reg, wd_reg} ^ inj_flip;
  end

  // software registers, error counters and interrupt
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      auto_reg <= AUTO_RST;
      inj_reg <= '0;
      stat_reg <= '0;
      mask_reg <= '0;
      err_addr_reg <= '0;
      sbe_cnt_reg <= '0;
      dbe_cnt_reg <= '0;
      irq_reg <= 1'h0;
    end else begin
      if (i_reg_wr && (i_reg_addr == REG_CTRL)) begin
        auto_reg <= i_reg_wdata[CTRL_AUTO_BIT];
        inj_reg <= i_reg_wdata[CTRL_INJ_LO +: INJ_W];
      end else if (st_reg == DS_WR) begin
        inj_reg <= '0; // one-shot: disarmed by the store it hits
      end
      if (i_reg_wr && (i_reg_addr == REG_MASK)) begin
        mask_reg <= i_reg_wdata[ST_W-1:0];
      end
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & mask_reg);
      if (sbe_ev || dbe_ev) err_addr_reg <= addr_reg;
      if (sbe_ev) sbe_cnt_reg <= sbe_cnt_reg + 16'h1;
      if (dbe_ev) dbe_cnt_reg <= dbe_cnt_reg + 16'h1;
    end
  end

  // read selection; unmapped offsets read zero
  always_comb begin
    case (i_reg_addr)
      REG_CTRL: rd_mux = REG_DW'({inj_reg, auto_reg});
      REG_STAT: rd_mux = REG_DW'(stat_reg);
      REG_MASK: rd_mux = REG_DW'(mask_reg);
      REG_SBE_FLAG: rd_mux = REG_DW'(stat_reg[ST_SBE_BIT]);
      REG_ERR_ADDR: rd_mux = REG_DW'(err_addr_reg);
      REG_SBE_CNT: rd_mux = REG_DW'(sbe_cnt_reg);
      REG_DBE_CNT: rd_mux = REG_DW'(dbe_cnt_reg);
      default: rd_mux = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) reg_rdata_reg <= '0;
    else reg_rdata_reg <= i_reg_rd ? rd_mux : '0;
  end
endmodule

// ==== rtl/ecc_host_end.sv ====
`timescale 1ns/1ps
module ecc_host_end (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  ecc_link_if.host bus,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [ecc_pkg::ADDR_W-1:0] i_cmd_addr,
  input wire logic [ecc_pkg::DATA_W-1:0] i_cmd_wdata,
  input wire logic [ecc_pkg::BE_W-1:0] i_cmd_be,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic o_rsp_write,
  output logic [ecc_pkg::DATA_W-1:0] o_rsp_rdata,
  output logic o_rsp_err
);
  import ecc_pkg::*;

  ecc_hst_t st_reg;
  logic [DIV_W-1:0] div_reg;
  logic hrate_reg;
  logic qrate_reg;
  logic aw_reg;
  logic ar_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [BE_W-1:0] be_reg;
  logic ready_reg;
  logic rsp_valid_reg;
  logic rsp_write_reg;
  logic [DATA_W-1:0] rsp_rdata_reg;
  logic rsp_err_reg;

  wire take = ready_reg && i_cmd_valid;
  wire wr_done = aw_reg && bus.awready && bus.wready;
  wire rd_done = ar_reg && bus.arready;

  assign bus.awaddr = addr_reg;
  assign bus.awvalid = aw_reg;
  assign bus.wdata = wdata_reg;
  assign bus.wstrb = be_reg;
  // single-beat requests: every write is a whole burst
  assign bus.wlast = 1'h1;
  assign bus.wvalid = aw_reg;
  assign bus.bready = 1'h1;
  assign bus.araddr = addr_reg;
  assign bus.arvalid = ar_reg;
  assign bus.rready = 1'h1;
  assign bus.hrate_en = hrate_reg;
  assign bus.qrate_en = qrate_reg;
  assign o_cmd_ready = ready_reg;
  assign o_rsp_valid = rsp_valid_reg;
  assign o_rsp_write = rsp_write_reg;
  assign o_rsp_rdata = rsp_rdata_reg;
  assign o_rsp_err = rsp_err_reg;

  // slower rates as enables locked to the one clock
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_reg <= '0;
      hrate_reg <= 1'h0;
      qrate_reg <= 1'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
      hrate_reg <= (div_reg[0] == 1'(HALF_DIV - 1));
      qrate_reg <= (div_reg == DIV_W'(QUARTER_DIV - 1));
    end
  end

  // one request in flight; the answer releases the next
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= HS_IDLE;
      aw_reg <= 1'h0;
      ar_reg <= 1'h0;
      addr_reg <= '0;
      wdata_reg <= '0;
      be_reg <= '0;
      ready_reg <= 1'h0;
      rsp_valid_reg <= 1'h0;
      rsp_write_reg <= 1'h0;
      rsp_rdata_reg <= '0;
      rsp_err_reg <= 1'h0;
    end else begin
      rsp_valid_reg <= 1'h0;
      case (st_reg)
        HS_IDLE: begin
          ready_reg <= !take;
          if (take) begin
            addr_reg <= i_cmd_addr;
            wdata_reg <= i_cmd_wdata;
            be_reg <= i_cmd_be;
            aw_reg <= i_cmd_write;
            ar_reg <= !i_cmd_write;
            st_reg <= i_cmd_write ? HS_WREQ : HS_RREQ;
          end
        end
        HS_WREQ: begin
          if (wr_done) begin
            aw_reg <= 1'h0;
            st_reg <= HS_WAIT;
          end
        end
        HS_RREQ: begin
          if (rd_done) begin
            ar_reg <= 1'h0;
            st_reg <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (bus.bvalid || bus.rvalid) begin
            rsp_valid_reg <= 1'h1;
            rsp_write_reg <= bus.bvalid;
            rsp_rdata_reg <= bus.rdata;
            rsp_err_reg <= bus.rvalid && (bus.rresp == RESP_DERR);
            ready_reg <= 1'h1;
            st_reg <= HS_IDLE;
          end
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end
endmodule

// ==== testbench/ecc_monitor.sv ====
`timescale 1ns/1ps
module ecc_monitor (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic awready,
  input wire logic wready,
  input wire logic [ecc_pkg::BE_W-1:0] wstrb,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [1:0] rresp,
  input wire logic rlast,
  input wire logic hrate_en,
  input wire logic qrate_en
);
  import ecc_pkg::*;
  // single clock domain, so one clocking and one reset for all
  default clocking mon_cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // write accepted only against a presented address and data beat
  property p_take;
    $rose(awready) |-> $past(awvalid && wvalid) && wready;
  endproperty
  a_take: assert property (p_take)
    else $error("write ready without request");
  // full word: encode stage adds one cycle before the store
  property p_full_lat;
    awready && wstrb == 4'hF |=> !bvalid [*2] ##1 bvalid;
  endproperty
  a_full_lat: assert property (p_full_lat)
    else $error("full write response not at third cycle");
  // partial word: read, check, encode, write back
  property p_part_lat;
    awready && wstrb != 4'hF |=> !bvalid [*4] ##1 bvalid;
  endproperty
  a_part_lat: assert property (p_part_lat)
    else $error("partial write response not at fifth cycle");
  // clean read at three, corrected read stalls two more
  property p_rd_lat;
    arready |=> (!rvalid [*2] ##1 rvalid) or (!rvalid [*4] ##1 rvalid);
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data at wrong cycle");
  property p_bresp;
    bvalid |-> bresp == RESP_OKAY;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response code not okay");
  property p_rresp;
    rvalid |-> rlast && (rresp == RESP_OKAY || rresp == RESP_DERR);
  endproperty
  a_rresp: assert property (p_rresp)
    else $error("read response code illegal");
  // one transaction at a time across the channels
  property p_excl;
    !(awready && arready);
  endproperty
  a_excl: assert property (p_excl)
    else $error("read and write taken together");
  property p_bpulse;
    (bvalid || rvalid) |=> !bvalid && !rvalid && !awready && !arready;
  endproperty
  a_bpulse: assert property (p_bpulse)
    else $error("response held or new request taken too early");
  property p_half;
    hrate_en |=> !hrate_en ##1 hrate_en;
  endproperty
  a_half: assert property (p_half)
    else $error("half rate enable not every second cycle");
  property p_quart;
    qrate_en |=> !qrate_en [*3] ##1 qrate_en;
  endproperty
  a_quart: assert property (p_quart)
    else $error("quarter rate enable not every fourth cycle");
endmodule

// ==== testbench/tb_ecc_partial_write_correction.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
  end \
end
module tb_ecc_partial_write_correction;
  import ecc_pkg::*;
  logic i_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic [REG_AW-1:0] i_reg_addr = 3'h0;
  logic [REG_DW-1:0] i_reg_wdata = 32'h0;
  logic i_reg_wr = 1'h0;
  logic i_reg_rd = 1'h0;
  logic [REG_DW-1:0] o_reg_rdata;
  logic o_irq;
  logic i_cmd_valid = 1'h0;
  logic i_cmd_write = 1'h0;
  logic [ADDR_W-1:0] i_cmd_addr = 4'h0;
  logic [DATA_W-1:0] i_cmd_wdata = 32'h0;
  logic [BE_W-1:0] i_cmd_be = 4'h0;
  logic o_cmd_ready, o_rsp_valid, o_rsp_write, o_rsp_err;
  logic [DATA_W-1:0] o_rsp_rdata;
  logic [DATA_W-1:0] model [DEPTH];
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;

  ecc_link_if lnk();
  ecc_dev_end ecc_dev_end_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(lnk.dev),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_irq(o_irq));
  ecc_host_end ecc_host_end_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(lnk.host),
    .i_cmd_valid(i_cmd_valid), .i_cmd_write(i_cmd_write),
    .i_cmd_addr(i_cmd_addr), .i_cmd_wdata(i_cmd_wdata),
    .i_cmd_be(i_cmd_be), .o_cmd_ready(o_cmd_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_write(o_rsp_write),
    .o_rsp_rdata(o_rsp_rdata), .o_rsp_err(o_rsp_err));
  ecc_monitor ecc_monitor_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .awvalid(lnk.awvalid),
    .wvalid(lnk.wvalid), .awready(lnk.awready), .wready(lnk.wready),
    .wstrb(lnk.wstrb), .bvalid(lnk.bvalid), .bresp(lnk.bresp),
    .arready(lnk.arready), .rvalid(lnk.rvalid), .rresp(lnk.rresp),
    .rlast(lnk.rlast), .hrate_en(lnk.hrate_en), .qrate_en(lnk.qrate_en));

  // clock and hang guard; whole run needs well under 3000 cycles
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // register port: one-cycle strobes, read data the cycle after
  task automatic reg_wr(input logic [REG_AW-1:0] a,
      input logic [REG_DW-1:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'h1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'h0;
  endtask
  task automatic reg_chk(input logic [REG_AW-1:0] a,
      input logic [REG_DW-1:0] exp);
    @(posedge i_clk);
    i_reg_rd <= 1'h1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'h0;
    @(negedge i_clk);
    `CHK(o_reg_rdata, exp)
  endtask

  // user command: hold valid until seen ready, then wait for the pulse
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
    int n;
    @(posedge i_clk);
    i_cmd_valid <= 1'h1;
    i_cmd_write <= w;
    i_cmd_addr <= a;
    i_cmd_wdata <= d;
    i_cmd_be <= be;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_cmd_ready !== 1'h1 && n < 100);
    @(posedge i_clk);
    i_cmd_valid <= 1'h0;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_rsp_valid !== 1'h1 && n < 100);
    `CHK(o_rsp_valid, 1'h1)
    `CHK(o_rsp_write, w)
  endtask
  // low enables keep the stored byte in the reference copy
  task automatic mem_put(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
    xfer(1'h1, a, d, be);
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) model[a][8*b +: 8] = d[8*b +: 8];
    end
  endtask
  task automatic mem_chk(input logic [ADDR_W-1:0] a);
    xfer(1'h0, a, 32'h0, 4'h0);
    `CHK(o_rsp_rdata, model[a])
    `CHK(o_rsp_err, 1'h0)
  endtask
  // uncorrectable word: flag beside the data, raw bits passed through
  task automatic rd_bad(input logic [ADDR_W-1:0] a);
    xfer(1'h0, a, 32'h0, 4'h0);
    `CHK(o_rsp_rdata, model[a] ^ 32'h3)
    `CHK(o_rsp_err, 1'h1)
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    // reset values, unmapped offset 7 included
    reg_chk(REG_CTRL, 32'h1);
    for (int r = 1; r < 8; r++) begin
      reg_chk(3'(r), 32'h0);
    end
    // read-only and unmapped places ignore writes
    reg_wr(REG_SBE_CNT, 32'hFFFF);
    reg_wr(3'h7, 32'hFFFFFFFF);
    reg_chk(REG_SBE_CNT, 32'h0);
    reg_chk(3'h7, 32'h0);
    reg_wr(REG_MASK, 32'h3);
    reg_chk(REG_MASK, 32'h3);
    // array has no reset, so every word is written whole first
    for (int a = 0; a < DEPTH; a++) begin
      mem_put(4'(a), 32'(32'h9E3779B9 * (a + 1)), 4'hF);
    end
    for (int a = 0; a < DEPTH; a++) begin
      mem_chk(4'(a));
    end
    // manual mode: dummy write with no enables leaves word intact
    reg_wr(REG_CTRL, 32'h0);
    reg_chk(REG_CTRL, 32'h0);
    mem_put(4'h5, 32'hFFFFFFFF, 4'h0);
    mem_chk(4'h5);
    // every enable pattern, back to back, merged and read back
    reg_wr(REG_CTRL, 32'h1);
    for (int be = 0; be < 16; be++) begin
      mem_put(4'h9, 32'(32'h0F1E2D3C + be * 32'h11111111), 4'(be));
      mem_chk(4'h9);
    end
    // clean traffic must leave no error trace and no interrupt
    reg_chk(REG_STAT, 32'h0);
    reg_chk(REG_SBE_CNT, 32'h0);
    reg_chk(REG_DBE_CNT, 32'h0);
    `CHK(o_irq, 1'h0)
    // auto mode, one armed flip: fixed in place before the answer
    reg_wr(REG_CTRL, 32'h3);
    mem_put(4'h2, 32'hA5A5A5A5, 4'hF);
    reg_chk(REG_CTRL, 32'h1);
    mem_chk(4'h2);
    reg_chk(REG_SBE_FLAG, 32'h1);
    reg_chk(REG_ERR_ADDR, 32'h2);
    `CHK(o_irq, 1'h1)
    // a second read is clean only if the fix was written back
    mem_chk(4'h2);
    reg_chk(REG_SBE_CNT, 32'h1);
    reg_wr(REG_STAT, 32'h3);
    reg_chk(REG_STAT, 32'h0);
    `CHK(o_irq, 1'h0)
    // manual mode: the fault stays until a write with no enables
    reg_wr(REG_CTRL, 32'h2);
    mem_put(4'h3, 32'h3C3C3C3C, 4'hF);
    mem_chk(4'h3);
    mem_chk(4'h3);
    reg_chk(REG_SBE_CNT, 32'h3);
    reg_chk(REG_ERR_ADDR, 32'h3);
    mem_put(4'h3, 32'h0, 4'h0);
    mem_chk(4'h3);
    reg_chk(REG_SBE_CNT, 32'h4);
    // two armed flips: flagged read, then a partial write heals it
    reg_wr(REG_STAT, 32'h3);
    reg_wr(REG_CTRL, 32'h7);
    mem_put(4'h6, 32'h12345678, 4'hF);
    rd_bad(4'h6);
    reg_chk(REG_STAT, 32'h2);
    `CHK(o_irq, 1'h1)
    mem_put(4'h6, 32'h000000EE, 4'h1);
    mem_chk(4'h6);
    reg_chk(REG_DBE_CNT, 32'h2);
    reg_chk(REG_SBE_CNT, 32'h4);
    reg_chk(REG_ERR_ADDR, 32'h6);
    // reset in mid-run restores settings, array keeps contents
    reg_wr(REG_CTRL, 32'h0);
    @(posedge i_clk);
    i_sys_rst <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    reg_chk(REG_CTRL, 32'h1);
    reg_chk(REG_MASK, 32'h0);
    reg_chk(REG_DBE_CNT, 32'h0);
    mem_chk(4'h9);
    give_verdict();
  end
endmodule
